// ==== rtl/irq_agg_pkg.sv ====
// package: register map, vector layout and source slots of the interrupt aggregator
package irq_agg_pkg;

  // register offsets (byte addresses, one word each)
  localparam logic [3:0] off_interrupt_vector = 4'h0;
  localparam logic [3:0] off_processor_config = 4'h4;
  localparam logic [3:0] off_status           = 4'h8;

  // vector field layout
  localparam int vec_idx_lsb = 1;
  localparam int vec_grp_lsb = 4;
  localparam logic [7:0] vector_none = 8'h00;

  // processor config bit and reset value
  localparam int                cfg_irq_one_sel_bit = 0;
  localparam logic [7:0] cfg_reset           = 8'h00;

  // number of source slots (8 groups of 8 used in slot space, 64 vectors)
  localparam int n_slots = 64;

  // source slot numbers: group*8 + index
  localparam int slot_out_ep1     = 8'h12 >> 1;
  localparam int slot_out_ep2     = 8'h14 >> 1;
  localparam int slot_out_ep3     = 8'h16 >> 1;
  localparam int slot_in_ep1      = 8'h22 >> 1;
  localparam int slot_in_ep2      = 8'h24 >> 1;
  localparam int slot_in_ep3      = 8'h26 >> 1;
  localparam int slot_setup_ovw   = 8'h30 >> 1;
  localparam int slot_setup_rx    = 8'h32 >> 1;
  localparam int slot_power_on    = 8'h34 >> 1;
  localparam int slot_power_off   = 8'h36 >> 1;
  localparam int slot_resume      = 8'h38 >> 1;
  localparam int slot_suspend     = 8'h3a >> 1;
  localparam int slot_func_reset  = 8'h3c >> 1;
  localparam int slot_tx_empty    = 8'h40 >> 1;
  localparam int slot_rx_full     = 8'h42 >> 1;
  localparam int slot_in_ep0      = 8'h44 >> 1;
  localparam int slot_out_ep0     = 8'h46 >> 1;

  // grouped event inputs from the usb and two-wire blocks
  typedef struct packed {
    logic [3:0] out_ep;                 // bit0 endpoint 0 .. bit3 endpoint 3
    logic [3:0] in_ep;
    logic       setup_overwrite_event;
    logic       setup_received_event;
    logic       port_power_on_event;
    logic       port_power_off_event;
    logic       function_resume_event;
    logic       function_suspend_event;
    logic       function_reset_event;
    logic       twowire_tx_empty;
    logic       twowire_rx_full;
  } irq_sources_t;

endpackage : irq_agg_pkg

// ==== rtl/vectored_interrupt_aggregator.sv ====
// vectored interrupt aggregator with avalon-mm register slave
// Notes on behaviour
// - all extra sources are ORed into the core interrupt-zero request
// - core interrupt zero comes only from internal logic; interrupt one comes from pins
// - vector space covers up to 64 sources
// - vector register names the source behind the interrupt-zero trap
// - a write to the vector retires it and loads the next pending, except a write in the edge right after a retire
// - vector bit zero always reads zero, read only
// - vector reads zero when nothing is pending
// - within one group earliest arrival is reported first
// - group 7 highest priority, group 0 lowest
// - fixed priority by group only, group 4 (vectors 40-4e) highest used, 00 means none
// - output endpoints 1-3 at 12-16, input endpoints 1-3 at 22-26
// - function events in group 3, vector 3e reserved
// - group 4: tx empty, rx full, input and output endpoint 0
// - port-2 inputs, active low, ORed for interrupt one
// - interrupt one also goes to suspend/resume wake logic
// - config bit picks pin 3.3 (0) or port-2 OR (1) for interrupt one
// - active-low external copy of the aggregated interrupt
`timescale 1ns/1ps
module vectored_interrupt_aggregator
  import irq_agg_pkg::*;
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // avalon-mm slave
  input  wire logic [3:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // internal event pulses
  input  wire irq_agg_pkg::irq_sources_t  sources,
  // pins
  input  wire logic [7:0]                 port2_in,
  input  wire logic                       port3_pin3_in,
  // to the core and system
  output logic                            core_irq_zero,
  output logic                            core_irq_one,
  output logic                            wake_request,
  output logic                            external_irq_out_n
);
  import irq_agg_pkg::*;

  // vector assembly from group and index
  function automatic logic [7:0] make_vector(input logic [5:0] slot);
    make_vector = {1'b0, slot[5:3], slot[2:0], 1'b0};
  endfunction : make_vector

  // map the packed source struct onto slot positions
  logic [n_slots-1:0] raw_evt;
  always_comb begin
    raw_evt                  = '0;
    raw_evt[slot_out_ep1]    = sources.out_ep[1];
    raw_evt[slot_out_ep2]    = sources.out_ep[2];
    raw_evt[slot_out_ep3]    = sources.out_ep[3];
    raw_evt[slot_in_ep1]     = sources.in_ep[1];
    raw_evt[slot_in_ep2]     = sources.in_ep[2];
    raw_evt[slot_in_ep3]     = sources.in_ep[3];
    raw_evt[slot_setup_ovw]  = sources.setup_overwrite_event;
    raw_evt[slot_setup_rx]   = sources.setup_received_event;
    raw_evt[slot_power_on]   = sources.port_power_on_event;
    raw_evt[slot_power_off]  = sources.port_power_off_event;
    raw_evt[slot_resume]     = sources.function_resume_event;
    raw_evt[slot_suspend]    = sources.function_suspend_event;
    raw_evt[slot_func_reset] = sources.function_reset_event;
    raw_evt[slot_tx_empty]   = sources.twowire_tx_empty;
    raw_evt[slot_rx_full]    = sources.twowire_rx_full;
    raw_evt[slot_in_ep0]     = sources.in_ep[0];
    raw_evt[slot_out_ep0]    = sources.out_ep[0];
  end

  // rising-edge detect: a held level counts once per assertion
  logic [n_slots-1:0] evt_prev;
  logic [n_slots-1:0] evt_new;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      evt_prev <= '0;
    end else begin
      evt_prev <= raw_evt;
    end
  end
  assign evt_new = raw_evt & ~evt_prev;

  // arrival stamps: per slot, count of earlier pending members in its group
  // a newcomer takes rank = number already pending; retire shifts others down
  logic [n_slots-1:0] pending;
  logic [2:0]         rank [n_slots];
  logic [7:0]         interrupt_vector;
  logic               retire;
  logic [5:0]         cur_slot;

  // current pick: highest group with pending, its rank-zero member
  logic       any_pending;
  logic [5:0] next_slot;
  always_comb begin
    any_pending = 1'b0;
    next_slot   = '0;
    for (int s = 0; s < n_slots; s++) begin
      // ascending scan: later (higher group) hits override
      if (pending[s] && rank[s] == 3'h0) begin
        any_pending = 1'b1;
        next_slot   = 6'(s);
      end
    end
  end

  // pending and rank bookkeeping, one generate slice per slot
  genvar g;
  generate
    for (g = 0; g < n_slots; g++) begin : g_slot
      localparam int grp = g / 8;
      logic [2:0] group_count;
      always_comb begin
        group_count = '0;
        for (int k = grp * 8; k < grp * 8 + 8; k++) begin
          if (pending[k] && k != g) begin
            group_count = group_count + 3'h1;
          end
        end
      end
      logic retire_here;
      logic retire_grp;
      assign retire_here = retire && pending[g] && cur_slot == 6'(g);
      assign retire_grp  = retire && cur_slot[5:3] == 3'(grp) && pending[cur_slot];
      always_ff @(posedge clk) begin
        if (!resetn) begin
          pending[g] <= 1'b0;
          rank[g]    <= 3'h0;
        end else if (retire_here) begin
          // a fresh event at the retire edge re-arms it at the back
          pending[g] <= evt_new[g];
          rank[g]    <= group_count - 3'h0;
        end else if (pending[g]) begin
          if (retire_grp && rank[g] != 3'h0) begin
            rank[g] <= rank[g] - 3'h1;
          end
        end else if (evt_new[g]) begin
          pending[g] <= 1'b1;
          rank[g]    <= retire_grp ? group_count - 3'h1 : group_count;
        end
      end
    end
  endgenerate

  // presented vector register: reloads whenever the pick changes
  // for one edge after a retire the old vector still stands, so a write
  // in that cycle finds its slot no longer pending and is dropped
  always_ff @(posedge clk) begin
    if (!resetn) begin
      interrupt_vector <= vector_none;
      cur_slot         <= '0;
    end else begin
      cur_slot         <= next_slot;
      interrupt_vector <= any_pending ? make_vector(next_slot) : vector_none;
    end
  end

  // processor configuration register, software steers interrupt one source
  logic [7:0] processor_config_register;
  logic       bus_wr;
  logic       bus_rd;
  logic       rd_done;
  assign bus_wr = avs_write && !avs_read;
  assign bus_rd = avs_read && !avs_write;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      processor_config_register <= cfg_reset;
    end else if (bus_wr && avs_address == off_processor_config && avs_byteenable[0]) begin
      processor_config_register <= avs_writedata[7:0];
    end
  end

  // a write to the vector offset retires the shown vector, except a write in the edge right after a retire
  // retire only while the register shows a vector other than vector_none
  assign retire = bus_wr && avs_address == off_interrupt_vector
                  && interrupt_vector != vector_none;

  // reads take one wait cycle so readdata comes from a flop; writes need none
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_done      <= 1'b0;
      avs_readdata <= '0;
    end else begin
      rd_done <= bus_rd && !rd_done;
      if (bus_rd && !rd_done) begin
        unique case (avs_address)
          off_interrupt_vector: avs_readdata <= {24'h0, interrupt_vector};
          off_processor_config: avs_readdata <= {24'h0, processor_config_register};
          off_status:           avs_readdata <= {30'h0, core_irq_one, core_irq_zero};
          default:              avs_readdata <= '0; // unmapped reads zero
        endcase
      end
    end
  end
  assign avs_waitrequest = bus_rd && !rd_done;

  // port pins pass two flops before any logic looks at them
  logic [7:0] p2_meta;
  logic [7:0] p2_sync;
  logic       p33_meta;
  logic       p33_sync;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      p2_meta  <= 8'hff;
      p2_sync  <= 8'hff;
      p33_meta <= 1'b1;
      p33_sync <= 1'b1;
    end else begin
      p2_meta  <= port2_in;
      p2_sync  <= p2_meta;
      p33_meta <= port3_pin3_in;
      p33_sync <= p33_meta;
    end
  end

  // interrupt one: active-low port-2 lines ORed, or pin 3.3 (active-low core input)
  logic port2_any;
  assign port2_any = |(~p2_sync);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      core_irq_one <= 1'b1;
      wake_request <= 1'b0;
    end else begin
      core_irq_one <= processor_config_register[cfg_irq_one_sel_bit] ? ~port2_any : p33_sync;
      wake_request <= processor_config_register[cfg_irq_one_sel_bit] ? port2_any : ~p33_sync;
    end
  end

  // interrupt zero: active-low level, pin copy for an outside processor
  assign core_irq_zero      = ~(|pending);
  assign external_irq_out_n = ~(|pending);

  // checks
  AST_VEC_EVEN: assert property (@(posedge clk) disable iff (!resetn)
    interrupt_vector[0] == 1'b0) else $error("vector bit zero set");
  AST_VEC_IDLE: assert property (@(posedge clk) disable iff (!resetn)
    !(|pending) |=> interrupt_vector == vector_none) else $error("idle vector not zero");
  AST_IRQ0_LEVEL: assert property (@(posedge clk) disable iff (!resetn)
    $rose(|pending) |-> !core_irq_zero) else $error("irq zero not asserted");
  AST_EXT_COPY: assert property (@(posedge clk) disable iff (!resetn)
    external_irq_out_n == core_irq_zero) else $error("external copy differs");
  AST_RANGE: assert property (@(posedge clk) disable iff (!resetn)
    interrupt_vector <= 8'h4e) else $error("vector above 4e");
  AST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    pending[slot_tx_empty] && !(retire && cur_slot == 6'(slot_tx_empty)) |=> pending[slot_tx_empty])
    else $error("pending lost without retire");
  // retire walk: a write on the shown slot, then that slot gone one edge later
  sequence s_retire_write;
    retire && !evt_new[cur_slot];
  endsequence
  sequence s_shown_slot_cleared;
    !pending[$past(cur_slot)];
  endsequence
  AST_RETIRE: assert property (@(posedge clk) disable iff (!resetn)
    s_retire_write |=> s_shown_slot_cleared) else $error("retire kept source");
  AST_SEL_P2: assert property (@(posedge clk) disable iff (!resetn)
    processor_config_register[cfg_irq_one_sel_bit] && $stable(processor_config_register) && port2_any
    |=> !core_irq_one) else $error("port-2 select failed");
  AST_WAKE: assert property (@(posedge clk) disable iff (!resetn)
    wake_request == !core_irq_one) else $error("wake not following irq one");
  AST_GROUP: assert property (@(posedge clk) disable iff (!resetn)
    pending[slot_tx_empty] && pending[slot_out_ep1] && $stable(pending) |=> interrupt_vector[7:4] >= 4'h4)
    else $error("lower group shown first");

  // lone arrival on the transmit-empty slot while nothing else is pending
  sequence s_lone_tx_arrival;
    !(|pending) && evt_new[slot_tx_empty] && $onehot(evt_new);
  endsequence
  // two flops in the path: pending first, then the presented vector
  sequence s_tx_vector_shown;
    ##2 interrupt_vector[7:1] == 7'(slot_tx_empty);
  endsequence
  // a later arrival in group 3 while an earlier member still waits
  sequence s_later_in_group;
    pending[slot_func_reset] && !pending[slot_suspend] && evt_new[slot_suspend] && !retire;
  endsequence
  // pin low with select 1, and select 1 again two edges later, when the pin has crossed both synchroniser flops
  sequence s_port2_low_at_pin;
    processor_config_register[cfg_irq_one_sel_bit] && !(&port2_in)
    ##2 processor_config_register[cfg_irq_one_sel_bit];
  endsequence
  AST_EVT_IRQ0: assert property (@(posedge clk) disable iff (!resetn)
    (|evt_new) |=> !core_irq_zero) else $error("event did not pull irq zero low");
  AST_VEC_SHOWN: assert property (@(posedge clk) disable iff (!resetn)
    s_lone_tx_arrival |-> s_tx_vector_shown) else $error("lone source not shown");
  AST_ARRIVAL: assert property (@(posedge clk) disable iff (!resetn)
    s_later_in_group |=> rank[slot_suspend] > rank[slot_func_reset]) else $error("later arrival ranked first");
  AST_SEL_PIN: assert property (@(posedge clk) disable iff (!resetn)
    !processor_config_register[cfg_irq_one_sel_bit] |=> core_irq_one == $past(p33_sync))
    else $error("pin 3.3 select failed");
  AST_P2_PATH: assert property (@(posedge clk) disable iff (!resetn)
    s_port2_low_at_pin |=> !core_irq_one) else $error("port-2 low not passed to irq one");

endmodule : vectored_interrupt_aggregator

// ==== testbench/core_fw_model.sv ====
// firmware-side model of the core: level view of irq zero, edge count of irq one
`timescale 1ns/1ps
module core_fw_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // core interrupt inputs
  input  wire logic core_irq_zero,
  input  wire logic core_irq_one,
  // what the firmware sees
  output int        irq_one_edges,
  output logic      irq_zero_active
);
  logic one_q;
  // irq zero taken as an active-low level, never as an edge
  assign irq_zero_active = (core_irq_zero === 1'b0);
  // irq one taken on its falling edge only; a long low counts once
  always @(posedge clk) begin
    if (!resetn) begin
      one_q <= 1'b1;
      irq_one_edges <= 0;
    end else begin
      one_q <= core_irq_one;
      if (one_q && !core_irq_one) irq_one_edges <= irq_one_edges + 1;
    end
  end
endmodule : core_fw_model

// ==== testbench/vectored_interrupt_aggregator_bench.sv ====
// self-checking bench of the vectored interrupt aggregator
`timescale 1ns/1ps
module vectored_interrupt_aggregator_bench;
  import irq_agg_pkg::*;
  logic         clk = 0, resetn = 0, avs_read = 0, avs_write = 0, port3_pin3_in = 1;
  logic [3:0]   avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0]  avs_writedata = 32'h0, avs_readdata, q;
  logic         avs_waitrequest, core_irq_zero, core_irq_one, wake_request, external_irq_out_n, irq_zero_active;
  logic [7:0]   port2_in = 8'hff;
  irq_sources_t sources = '0;
  int           mismatches = 0, n_tests = 0, seed = 32'h7ff715ab, irq_one_edges, pick;
  int           arr[$];
  int           ord[6] = '{14, 2, 3, 6, 0, 2};
  logic [16:0]  used;
  // vector of each bit of the packed source struct, bit 0 first
  logic [7:0]   vt[17] = '{8'h42, 8'h40, 8'h3c, 8'h3a, 8'h38, 8'h36, 8'h34, 8'h32, 8'h30,
                           8'h44, 8'h22, 8'h24, 8'h26, 8'h46, 8'h12, 8'h14, 8'h16};

  always #12.5 clk = ~clk;

  vectored_interrupt_aggregator vectored_interrupt_aggregator_i (.clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sources, .port2_in,
    .port3_pin3_in, .core_irq_zero, .core_irq_one, .wake_request, .external_irq_out_n);
  core_fw_model core_fw_model_i (.clk, .resetn, .core_irq_zero, .core_irq_one, .irq_one_edges,
    .irq_zero_active);

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one avalon transfer, held until waitrequest is sampled low; idle edge after
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // no local limit: a hung wait is ended by the watchdog
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  // one-cycle event on a struct bit, then time for it to reach the vector
  task automatic pulse(input int b);
    sources <= irq_sources_t'(17'h1 << b);
    @(posedge clk);
    sources <= '0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // earliest arrival within the highest waiting group
  function automatic int next_pick();
    int best = 0;
    foreach (arr[i]) if (vt[arr[i]][7:4] > vt[arr[best]][7:4]) best = i;
    return best;
  endfunction : next_pick

  // firmware loop: read the vector, dispatch, retire with any data
  task automatic drain();
    while (arr.size() > 0) begin
      pick = next_pick();
      check("irq zero level", irq_zero_active, 1);
      check("external irq", external_irq_out_n, 0);
      bus(0, off_interrupt_vector, 0);
      check("vector", q, {24'h0, vt[arr[pick]]});
      bus(1, off_interrupt_vector, $random(seed));
      arr.delete(pick);
    end
    bus(0, off_interrupt_vector, 0);
    check("vector idle", q, 0);
    check("irq zero idle", {core_irq_zero, external_irq_out_n}, 2'b11);
  endtask : drain

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    bus(0, off_interrupt_vector, 0);
    check("vector reset", q, 0);
    bus(0, off_processor_config, 0);
    check("config reset", q, 0);
    bus(1, 4'hc, 32'hff);
    bus(0, 4'hc, 0);
    check("unmapped", q, 0);
    // retiring with nothing shown must leave everything idle
    bus(1, off_interrupt_vector, 32'h5a);
    check("pins idle", {core_irq_zero, external_irq_out_n, core_irq_one, wake_request}, 4'b1110);
    // every source alone hits its own slot
    for (int b = 0; b < 17; b++) begin
      pulse(b);
      arr.push_back(b);
      drain();
    end
    // groups out of arrival order, and a repeat of a pending slot merged
    foreach (ord[i]) begin
      pulse(ord[i]);
      if (i < 5) arr.push_back(ord[i]);
    end
    drain();
    // random bursts, repeats included
    repeat (8) begin
      used = '0;
      repeat (6) begin
        pick = {$random(seed)} % 17;
        if (!used[pick]) arr.push_back(pick);
        used[pick] = 1'b1;
        pulse(pick);
      end
      drain();
    end
    // select 0: pin 3.3 drives irq one and wake
    port3_pin3_in <= 1'b0;
    repeat (4) @(posedge clk);
    check("irq one pin", {core_irq_one, wake_request}, 2'b01);
    port3_pin3_in <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1, off_processor_config, 32'h1);
    bus(0, off_processor_config, 0);
    check("config", q, 32'h1);
    // select 1: each port-2 bit alone, pin 3.3 random and ignored
    for (int b = 0; b < 8; b++) begin
      port2_in <= ~(8'h1 << b);
      port3_pin3_in <= 1'($random(seed));
      repeat (4) @(posedge clk);
      check("irq one port2", {core_irq_one, wake_request}, 2'b01);
      bus(0, off_status, 0);
      check("status", q, 32'h1);
      port2_in <= 8'hff;
      repeat (4) @(posedge clk);
      check("irq one idle", {core_irq_one, wake_request}, 2'b10);
    end
    check("irq one edges", irq_one_edges, 9);
    end_sim();
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : vectored_interrupt_aggregator_bench
